// [cif_pkg.sv]
// Notes on behaviour
// RULE_01 - Flag bit 7 is set on every change of the card busy level and cleared by a read of the flag register.
// RULE_02 - Flag bit 6 is set when a response has been received and cleared by a read of the flag register.
// RULE_03 - Flag bit 5 is set when a command has been sent and cleared by a read of the flag register.
// RULE_04 - Flag bit 4 is set when a stream or block frame ends and cleared by a read of the flag register.
// RULE_05 - Flag bit 3 rises when FIFO two fills and falls when it empties; a read leaves it alone.
// RULE_06 - Flag bit 2 rises when FIFO one fills and falls when it empties.
// RULE_07 - Flag bit 1 rises when FIFO two empties and falls when it fills.
// RULE_08 - Flag bit 0 rises when FIFO one empties and falls when it fills.
// RULE_09 - The flag register is read-only, and writes to it change no flag.
// RULE_10 - The request is high while any flag is set whose mask bit is zero; a mask bit of one blocks its flag.
// RULE_11 - The mask register comes out of reset as all ones.
// RULE_12 - Writing the command port pushes the command FIFO, reading it pops the response FIFO; it reads all ones after reset.
// RULE_13 - Writing the data port pushes the data FIFO, reading it pops it; it reads all ones after reset.
// RULE_14 - The card clock comes from an 8-bit divider register that resets to zero.
// RULE_15 - Card clock and event capture run only while the controller clock enable is high.
// RULE_16 - The command FIFO shows locked while sending, and software must not write the command port then.
// RULE_17 - The card clock rate is the peripheral clock divided by divider value plus one.
package cif_pkg;
   localparam logic [7:0] CIF_DATA_PORT_ADDR = 8'hDC;
   localparam logic [7:0] CIF_CMD_PORT_ADDR = 8'hDD;
   localparam logic [7:0] CIF_MASK_ADDR = 8'hDF;
   localparam logic [7:0] CIF_FLAGS_ADDR = 8'hE7;
   localparam logic [7:0] CIF_DIV_ADDR = 8'hED;
   localparam int CIF_BUSY_BIT = 7;
   localparam int CIF_RESP_BIT = 6;
   localparam int CIF_CMD_BIT = 5;
   localparam int CIF_FRAME_BIT = 4;
   localparam int CIF_F2_FULL_BIT = 3;
   localparam int CIF_F1_FULL_BIT = 2;
   localparam int CIF_F2_EMPTY_BIT = 1;
   localparam int CIF_F1_EMPTY_BIT = 0;
   localparam logic [7:0] CIF_READ_CLEAR_BITS = 8'hF0;
   localparam logic [7:0] CIF_PORT_RESET = 8'hFF;
   localparam logic [7:0] CIF_MASK_RESET = 8'hFF;
   localparam logic [7:0] CIF_FLAGS_RESET = 8'h00;
   localparam logic [7:0] CIF_DIV_RESET = 8'h00;
   localparam logic [7:0] CIF_UNMAPPED_READ = 8'h00;

   typedef struct packed {
      logic [7:0] addr;
      logic wr;
      logic rd;
      logic [7:0] wdata;
   } cif_sfr_req_type;

   typedef struct packed {
      logic busy_level;
      logic resp_done;
      logic cmd_done;
      logic frame_done;
      logic f2_full;
      logic f1_full;
      logic f2_empty;
      logic f1_empty;
   } cif_event_type;
endpackage

// [cif_regs.sv]
`timescale 1ns/10ps
module cif_regs (
   input wire logic clk, // Peripheral clock, 100 MHz
   input wire logic rst, // Synchronous reset, active high
   input wire cif_pkg::cif_sfr_req_type sfr, // Special function register access
   output logic [7:0] sfr_rdata, // Read data, valid the cycle after rd
   input wire cif_pkg::cif_event_type evt, // Events and levels from the line engines
   input wire logic controller_clock_enable, // Controller run enable
   input wire logic cmd_sending, // Command engine is sending
   input wire logic [7:0] resp_head, // Head byte of response FIFO
   input wire logic [7:0] data_head, // Head byte of data FIFO
   output logic cmd_push, // Push pulse to command FIFO
   output logic resp_pop, // Pop pulse to response FIFO
   output logic data_push, // Push pulse to data FIFO
   output logic data_pop, // Pop pulse from data FIFO
   output logic [7:0] push_byte, // Byte carried with a push
   output logic command_fifo_lock, // Command FIFO busy
   output logic card_clk_tick, // One cycle per card clock period
   output logic card_irq // Interrupt request, active high
);
   import cif_pkg::*;

   logic [7:0] flags_r;
   logic [7:0] flags_nxt;
   logic [7:0] mask_r;
   logic [7:0] div_r;
   logic [7:0] div_cnt_r;
   logic [7:0] div_cnt_nxt;
   logic busy_prev_r;
   logic [7:0] rdata_r;
   logic [7:0] rdata_nxt;
   logic cmd_push_r;
   logic resp_pop_r;
   logic data_push_r;
   logic data_pop_r;
   logic [7:0] push_byte_r;
   logic lock_r;
   logic tick_r;
   logic irq_r;

   // ----------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------
   function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
      hit = (a == target);
   endfunction

   wire rd_flags = sfr.rd && hit(sfr.addr, CIF_FLAGS_ADDR);
   wire wr_mask = sfr.wr && hit(sfr.addr, CIF_MASK_ADDR);
   wire wr_div = sfr.wr && hit(sfr.addr, CIF_DIV_ADDR);
   // A write while locked is dropped so a half-sent command is not corrupted
   wire wr_cmd = sfr.wr && hit(sfr.addr, CIF_CMD_PORT_ADDR) && !lock_r; // see RULE_16
   wire rd_cmd = sfr.rd && hit(sfr.addr, CIF_CMD_PORT_ADDR); // see RULE_12
   wire wr_data = sfr.wr && hit(sfr.addr, CIF_DATA_PORT_ADDR); // see RULE_13
   wire rd_data = sfr.rd && hit(sfr.addr, CIF_DATA_PORT_ADDR); // see RULE_13
   wire en = controller_clock_enable; // see RULE_15

   // ----------------------------------------------------------------
   // Flag update
   // ----------------------------------------------------------------
   wire [7:0] sticky_set = en ? {evt.busy_level != busy_prev_r, evt.resp_done, evt.cmd_done, evt.frame_done, 4'h0}
                              : 8'h00; // see RULE_01
   // Set beats the read clear so no event is lost
   wire [7:0] read_clr = rd_flags ? CIF_READ_CLEAR_BITS : 8'h00; // see RULE_02
   wire f2f = evt.f2_full ? 1'b1 : (evt.f2_empty ? 1'b0 : flags_r[CIF_F2_FULL_BIT]); // see RULE_05
   wire f1f = evt.f1_full ? 1'b1 : (evt.f1_empty ? 1'b0 : flags_r[CIF_F1_FULL_BIT]); // see RULE_06
   wire f2e = evt.f2_empty ? 1'b1 : (evt.f2_full ? 1'b0 : flags_r[CIF_F2_EMPTY_BIT]); // see RULE_07
   wire f1e = evt.f1_empty ? 1'b1 : (evt.f1_full ? 1'b0 : flags_r[CIF_F1_EMPTY_BIT]); // see RULE_08
   wire [3:0] level_now = en ? {f2f, f1f, f2e, f1e} : flags_r[3:0];
   // No write path reaches the flags
   assign flags_nxt = {(flags_r[7:4] & ~read_clr[7:4]) | sticky_set[7:4], level_now}; // see RULE_09 RULE_03 RULE_04

   // ----------------------------------------------------------------
   // Read mux and card clock divider
   // ----------------------------------------------------------------
   assign rdata_nxt = rd_flags ? flags_r :
                      (sfr.rd && hit(sfr.addr, CIF_MASK_ADDR)) ? mask_r :
                      (sfr.rd && hit(sfr.addr, CIF_DIV_ADDR)) ? div_r :
                      rd_cmd ? resp_head :
                      rd_data ? data_head :
                      sfr.rd ? CIF_UNMAPPED_READ : rdata_r;
   wire div_wrap = (div_cnt_r >= div_r); // see RULE_17
   assign div_cnt_nxt = (!en || div_wrap) ? 8'h00 : div_cnt_r + 8'h01;

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         flags_r <= CIF_FLAGS_RESET;
         mask_r <= CIF_MASK_RESET; // see RULE_11
         div_r <= CIF_DIV_RESET; // see RULE_14
         div_cnt_r <= 8'h00;
         busy_prev_r <= 1'b0;
         rdata_r <= CIF_PORT_RESET; // see RULE_12 RULE_13
      end else begin
         flags_r <= flags_nxt;
         if (wr_mask) mask_r <= sfr.wdata;
         if (wr_div) div_r <= sfr.wdata; // see RULE_14
         div_cnt_r <= div_cnt_nxt;
         if (en) busy_prev_r <= evt.busy_level;
         rdata_r <= rdata_nxt;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         cmd_push_r <= 1'b0;
         resp_pop_r <= 1'b0;
         data_push_r <= 1'b0;
         data_pop_r <= 1'b0;
         push_byte_r <= 8'h00;
         lock_r <= 1'b0;
         tick_r <= 1'b0;
         irq_r <= 1'b0;
      end else begin
         cmd_push_r <= wr_cmd; // see RULE_12
         resp_pop_r <= rd_cmd;
         data_push_r <= wr_data;
         data_pop_r <= rd_data;
         if (wr_cmd || wr_data) push_byte_r <= sfr.wdata;
         lock_r <= cmd_sending; // see RULE_16
         tick_r <= en && div_wrap; // see RULE_15
         irq_r <= |(flags_r & ~mask_r); // see RULE_10
      end
   end

   assign sfr_rdata = rdata_r;
   assign cmd_push = cmd_push_r;
   assign resp_pop = resp_pop_r;
   assign data_push = data_push_r;
   assign data_pop = data_pop_r;
   assign push_byte = push_byte_r;
   assign command_fifo_lock = lock_r;
   assign card_clk_tick = tick_r;
   assign card_irq = irq_r;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   sequence s_busy_edge;
      en && (evt.busy_level != busy_prev_r);
   endsequence
   property p_busy_flag;
      @(posedge clk) disable iff (rst) s_busy_edge |=> flags_r[CIF_BUSY_BIT];
   endproperty
   a_busy_flag: assert property (p_busy_flag) else $error("busy change did not set flag"); // see RULE_01

   property p_resp_flag;
      @(posedge clk) disable iff (rst) en && evt.resp_done |=> flags_r[CIF_RESP_BIT];
   endproperty
   a_resp_flag: assert property (p_resp_flag) else $error("response end did not set flag"); // see RULE_02

   property p_cmd_flag;
      @(posedge clk) disable iff (rst) en && evt.cmd_done && rd_flags |=> flags_r[CIF_CMD_BIT];
   endproperty
   a_cmd_flag: assert property (p_cmd_flag) else $error("command end lost under read clear"); // see RULE_03

   property p_read_clear;
      @(posedge clk) disable iff (rst) rd_flags && sticky_set == 8'h00 |=> flags_r[7:4] == 4'h0;
   endproperty
   a_read_clear: assert property (p_read_clear) else $error("read did not clear sticky flags"); // see RULE_04

   sequence s_f2_fill;
      en && evt.f2_full;
   endsequence
   property p_f2_full;
      @(posedge clk) disable iff (rst) s_f2_fill |=> flags_r[CIF_F2_FULL_BIT] && !flags_r[CIF_F2_EMPTY_BIT];
   endproperty
   a_f2_full: assert property (p_f2_full) else $error("fifo two full flags wrong"); // see RULE_05 RULE_07

   property p_f1_empty;
      @(posedge clk) disable iff (rst)
         en && evt.f1_empty && !evt.f1_full |=> flags_r[CIF_F1_EMPTY_BIT] && !flags_r[CIF_F1_FULL_BIT];
   endproperty
   a_f1_empty: assert property (p_f1_empty) else $error("fifo one empty flags wrong"); // see RULE_06 RULE_08

   property p_flags_no_write;
      @(posedge clk) disable iff (rst)
         sfr.wr && hit(sfr.addr, CIF_FLAGS_ADDR) && !en && !rd_flags |=> $stable(flags_r);
   endproperty
   a_flags_no_write: assert property (p_flags_no_write) else $error("write changed flags"); // see RULE_09

   property p_irq;
      @(posedge clk) disable iff (rst) (|(flags_r & ~mask_r)) |=> card_irq;
   endproperty
   a_irq: assert property (p_irq) else $error("unmasked flag gave no request"); // see RULE_10

   property p_mask_reset;
      @(posedge clk) rst |=> mask_r == CIF_MASK_RESET && sfr_rdata == CIF_PORT_RESET;
   endproperty
   a_mask_reset: assert property (p_mask_reset) else $error("bad reset value"); // see RULE_11

   property p_cmd_push;
      @(posedge clk) disable iff (rst) wr_cmd |=> cmd_push && push_byte == $past(sfr.wdata);
   endproperty
   a_cmd_push: assert property (p_cmd_push) else $error("command write not pushed"); // see RULE_12

   property p_locked_write;
      @(posedge clk) disable iff (rst) sfr.wr && hit(sfr.addr, CIF_CMD_PORT_ADDR) && lock_r |=> !cmd_push;
   endproperty
   a_locked_write: assert property (p_locked_write) else $error("push while locked"); // see RULE_16

   property p_data_pop;
      @(posedge clk) disable iff (rst) rd_data |=> data_pop && sfr_rdata == $past(data_head);
   endproperty
   a_data_pop: assert property (p_data_pop) else $error("data read wrong"); // see RULE_13

   property p_no_tick_off;
      @(posedge clk) disable iff (rst) !en |=> !card_clk_tick;
   endproperty
   a_no_tick_off: assert property (p_no_tick_off) else $error("card clock while disabled"); // see RULE_15

   property p_div_zero;
      @(posedge clk) disable iff (rst) en && div_r == 8'h00 && !wr_div [*2] |=> card_clk_tick;
   endproperty
   a_div_zero: assert property (p_div_zero) else $error("divider zero not full rate"); // see RULE_17 RULE_14

   // ----------------------------------------------------------------
   // Request, ports, lock and freeze
   // ----------------------------------------------------------------
   property p_irq_low;
      @(posedge clk) disable iff (rst) !(|(flags_r & ~mask_r)) |=> !card_irq;
   endproperty
   a_irq_low: assert property (p_irq_low) else $error("request without unmasked flag"); // see RULE_10

   property p_mask_write;
      @(posedge clk) disable iff (rst) wr_mask |=> mask_r == $past(sfr.wdata);
   endproperty
   a_mask_write: assert property (p_mask_write) else $error("mask write lost"); // see RULE_10

   property p_div_write;
      @(posedge clk) disable iff (rst) wr_div |=> div_r == $past(sfr.wdata);
   endproperty
   a_div_write: assert property (p_div_write) else $error("divider write lost"); // see RULE_14

   property p_lock_follow;
      @(posedge clk) disable iff (rst) cmd_sending |=> command_fifo_lock;
   endproperty
   a_lock_follow: assert property (p_lock_follow) else $error("lock missing while sending"); // see RULE_16

   property p_lock_drop;
      @(posedge clk) disable iff (rst) !cmd_sending |=> !command_fifo_lock;
   endproperty
   a_lock_drop: assert property (p_lock_drop) else $error("lock stuck while idle"); // see RULE_16

   property p_resp_pop;
      @(posedge clk) disable iff (rst) rd_cmd |=> resp_pop && sfr_rdata == $past(resp_head);
   endproperty
   a_resp_pop: assert property (p_resp_pop) else $error("response read wrong"); // see RULE_12

   property p_data_push;
      @(posedge clk) disable iff (rst) wr_data |=> data_push && push_byte == $past(sfr.wdata);
   endproperty
   a_data_push: assert property (p_data_push) else $error("data write not pushed"); // see RULE_13

   property p_flags_read;
      @(posedge clk) disable iff (rst) rd_flags |=> sfr_rdata == $past(flags_r);
   endproperty
   a_flags_read: assert property (p_flags_read) else $error("flag read wrong"); // see RULE_09

   property p_rdata_hold;
      @(posedge clk) disable iff (rst) !sfr.rd |=> $stable(sfr_rdata);
   endproperty
   a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved without read"); // see RULE_12

   property p_no_push_idle;
      @(posedge clk) disable iff (rst) !wr_cmd |=> !cmd_push;
   endproperty
   a_no_push_idle: assert property (p_no_push_idle) else $error("command push without write"); // see RULE_12

   property p_no_pop_idle;
      @(posedge clk) disable iff (rst) !rd_data |=> !data_pop;
   endproperty
   a_no_pop_idle: assert property (p_no_pop_idle) else $error("data pop without read"); // see RULE_13

   // An event landing on the reading cycle must survive the clear
   sequence s_sticky_read;
      rd_flags && (sticky_set[7:4] != 4'h0);
   endsequence
   property p_set_beats_clear;
      @(posedge clk) disable iff (rst) s_sticky_read |=> flags_r[7:4] == $past(sticky_set[7:4]);
   endproperty
   a_set_beats_clear: assert property (p_set_beats_clear) else $error("event lost under read"); // see RULE_03

   sequence s_disabled;
      !en;
   endsequence
   property p_levels_frozen;
      @(posedge clk) disable iff (rst) s_disabled |=> flags_r[3:0] == $past(flags_r[3:0]);
   endproperty
   a_levels_frozen: assert property (p_levels_frozen) else $error("level flags moved while off"); // see RULE_15

   property p_sticky_frozen;
      @(posedge clk) disable iff (rst) s_disabled and !rd_flags |=> flags_r[7:4] == $past(flags_r[7:4]);
   endproperty
   a_sticky_frozen: assert property (p_sticky_frozen) else $error("event flags moved while off"); // see RULE_15

   property p_f1_full;
      @(posedge clk) disable iff (rst)
         en && evt.f1_full && !evt.f1_empty |=> flags_r[CIF_F1_FULL_BIT] && !flags_r[CIF_F1_EMPTY_BIT];
   endproperty
   a_f1_full: assert property (p_f1_full) else $error("fifo one full flags wrong"); // see RULE_06 RULE_08

   property p_f2_empty;
      @(posedge clk) disable iff (rst)
         en && evt.f2_empty && !evt.f2_full |=> flags_r[CIF_F2_EMPTY_BIT] && !flags_r[CIF_F2_FULL_BIT];
   endproperty
   a_f2_empty: assert property (p_f2_empty) else $error("fifo two empty flags wrong"); // see RULE_07 RULE_05

   property p_frame_flag;
      @(posedge clk) disable iff (rst) en && evt.frame_done |=> flags_r[CIF_FRAME_BIT];
   endproperty
   a_frame_flag: assert property (p_frame_flag) else $error("frame end did not set flag"); // see RULE_04

   property p_level_hold;
      @(posedge clk) disable iff (rst)
         en && ({evt.f2_full, evt.f1_full, evt.f2_empty, evt.f1_empty} == 4'h0) |=> $stable(flags_r[3:0]);
   endproperty
   a_level_hold: assert property (p_level_hold) else $error("level flags moved without cause"); // see RULE_05

   property p_tick_gap;
      @(posedge clk) disable iff (rst) en && !div_wrap |=> !card_clk_tick;
   endproperty
   a_tick_gap: assert property (p_tick_gap) else $error("card clock tick too early"); // see RULE_17
endmodule

// [cif_card_model.sv]
`timescale 1ns/10ps
module cif_card_model (
   input wire logic clk, // Peripheral clock
   input wire logic rst, // Synchronous reset
   input wire logic cmd_push, // Command byte handed to the line
   input wire logic [3:0] cmd_len, // Cycles a command occupies the line
   input wire logic resp_end, // Response reception finished
   input wire logic frame_end, // Data frame finished
   input wire logic [4:0] lvl, // Busy level, then full/empty levels
   output cif_pkg::cif_event_type evt, // Events toward the registers
   output logic cmd_sending // Command line busy
);
   import cif_pkg::*;
   // ----
   // Command line: busy for cmd_len cycles, done pulse on the last one
   // ----
   logic [3:0] left_r;
   always_ff @(posedge clk) begin
      if (rst)
         left_r <= 4'h0;
      else if (cmd_push)
         left_r <= cmd_len;
      else if (left_r != 4'h0)
         left_r <= left_r - 4'h1;
   end
   assign cmd_sending = (left_r != 4'h0);
   assign evt = {lvl[4], resp_end, left_r == 4'h1, frame_end, lvl[3:0]};
endmodule

// [tb_cif_regs.sv]
`timescale 1ns/10ps
module tb_cif_regs;
   import cif_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   cif_sfr_req_type sfr = '0;
   cif_event_type evt;
   logic [7:0] sfr_rdata, push_byte, b;
   logic [7:0] resp_head = 8'h00, data_head = 8'h00;
   logic cmd_push, resp_pop, data_push, data_pop, command_fifo_lock, card_clk_tick, card_irq, cmd_sending;
   logic en = 1'b0, frame_end = 1'b0, resp_end = 1'b0;
   logic [4:0] lvl = 5'h00;
   int miscompares = 0, n_compared = 0, ticks;
   logic [7:0] flags_m = 8'h00;
   always #5 clk = ~clk;
   cif_card_model cif_card_model_inst (.clk(clk), .rst(rst), .cmd_push(cmd_push), .cmd_len(4'h6),
      .resp_end(resp_end), .frame_end(frame_end), .lvl(lvl), .evt(evt), .cmd_sending(cmd_sending));
   cif_regs cif_regs_inst (.clk(clk), .rst(rst), .sfr(sfr), .sfr_rdata(sfr_rdata), .evt(evt),
      .controller_clock_enable(en), .cmd_sending(cmd_sending), .resp_head(resp_head),
      .data_head(data_head), .cmd_push(cmd_push), .resp_pop(resp_pop), .data_push(data_push),
      .data_pop(data_pop), .push_byte(push_byte), .command_fifo_lock(command_fifo_lock),
      .card_clk_tick(card_clk_tick), .card_irq(card_irq));
   // ----
   // Shared tasks
   // ----
   task automatic chk(string name, logic [7:0] seen, logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic acc(logic w, logic [7:0] a, logic [7:0] d);
      @(negedge clk);
      sfr = '{a, w, !w, d};
      @(negedge clk);
      sfr = '0;
   endtask
   task automatic rd(logic [7:0] a, logic [7:0] exp, string name);
      acc(1'b0, a, 8'h00);
      chk(name, sfr_rdata, exp);
      if (a == CIF_FLAGS_ADDR)
         flags_m = flags_m & 8'h0F;
   endtask
   task automatic summarize();
      $display("compared %0d miscompares %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // ----
   // Tests
   // ----
   initial begin
      #100000;
      miscompares++;
      summarize();
   end
   initial begin
      b = 8'($urandom(32'h84C6));
      repeat (12) @(negedge clk);
      rst = 1'b0;
      chk("rdata", sfr_rdata, CIF_PORT_RESET);
      rd(CIF_MASK_ADDR, 8'hFF, "mask");
      rd(CIF_DIV_ADDR, 8'h00, "div");
      rd(CIF_FLAGS_ADDR, 8'h00, "flags");
      rd(8'h80, CIF_UNMAPPED_READ, "unmapped");
      $display("test reset done");
      en = 1'b1;
      lvl[4] = 1'b1;
      b = 8'($urandom);
      acc(1'b1, CIF_CMD_PORT_ADDR, b);
      chk("cmd_push", cmd_push, 8'h01);
      chk("push_byte", push_byte, b);
      repeat (2) @(negedge clk);
      chk("lock", command_fifo_lock, 8'h01);
      acc(1'b1, CIF_CMD_PORT_ADDR, ~b);
      chk("cmd_push", cmd_push, 8'h00);
      resp_end = 1'b1;
      frame_end = 1'b1;
      @(negedge clk);
      resp_end = 1'b0;
      frame_end = 1'b0;
      flags_m = 8'hF0;
      repeat (8) @(negedge clk);
      acc(1'b1, CIF_FLAGS_ADDR, 8'h00);
      rd(CIF_FLAGS_ADDR, flags_m, "flags");
      rd(CIF_FLAGS_ADDR, flags_m, "flags");
      en = 1'b0;
      lvl[4] = 1'b0;
      resp_end = 1'b1;
      @(negedge clk);
      resp_end = 1'b0;
      acc(1'b1, CIF_FLAGS_ADDR, 8'hFF);
      rd(CIF_FLAGS_ADDR, flags_m, "flags_off");
      en = 1'b1;
      flags_m = 8'h80;
      rd(CIF_FLAGS_ADDR, flags_m, "busy");
      @(negedge clk);
      sfr = '{CIF_FLAGS_ADDR, 1'b0, 1'b1, 8'h00};
      resp_end = 1'b1;
      @(negedge clk);
      sfr = '0;
      resp_end = 1'b0;
      chk("flags_race", sfr_rdata, flags_m);
      flags_m = 8'h40;
      rd(CIF_FLAGS_ADDR, flags_m, "set_wins");
      $display("test events done");
      for (int i = 0; i < 4; i++) begin
         lvl[3:0] = 4'h1 << i;
         @(negedge clk);
         lvl[3:0] = 4'h0;
         flags_m = 8'((flags_m | (1 << i)) & ~(1 << (i ^ 2)));
         rd(CIF_FLAGS_ADDR, flags_m, "fifo");
         rd(CIF_FLAGS_ADDR, flags_m, "fifo");
      end
      $display("test fifo flags done");
      for (int i = 0; i < 8; i++) begin
         acc(1'b1, CIF_MASK_ADDR, ~(8'h01 << i));
         repeat (2) @(negedge clk);
         chk("irq", card_irq, 8'((flags_m >> i) & 1));
      end
      acc(1'b1, CIF_MASK_ADDR, 8'hFF);
      repeat (2) @(negedge clk);
      chk("irq", card_irq, 8'h00);
      rd(CIF_FLAGS_ADDR, flags_m, "masked");
      $display("test irq done");
      b = 8'($urandom);
      acc(1'b1, CIF_DATA_PORT_ADDR, b);
      chk("data_push", data_push, 8'h01);
      chk("push_byte", push_byte, b);
      data_head = 8'($urandom);
      resp_head = 8'($urandom);
      rd(CIF_DATA_PORT_ADDR, data_head, "data");
      chk("data_pop", data_pop, 8'h01);
      rd(CIF_CMD_PORT_ADDR, resp_head, "resp");
      chk("resp_pop", resp_pop, 8'h01);
      $display("test ports done");
      for (int k = 0; k < 4; k++) begin
         b = (k == 0) ? 8'h00 : 8'($urandom_range(7, 1));
         acc(1'b1, CIF_DIV_ADDR, b);
         rd(CIF_DIV_ADDR, b, "div");
         repeat (10) @(negedge clk);
         ticks = 0;
         repeat (4 * (b + 1)) begin
            @(negedge clk);
            ticks += card_clk_tick;
         end
         chk("ticks", 8'(ticks), 8'h04);
      end
      en = 1'b0;
      repeat (2) @(negedge clk);
      ticks = 0;
      repeat (20) begin
         @(negedge clk);
         ticks += card_clk_tick;
      end
      chk("ticks_off", 8'(ticks), 8'h00);
      $display("test divider done");
      chk("lock", command_fifo_lock, 8'h00);
      acc(1'b1, CIF_CMD_PORT_ADDR, b);
      chk("cmd_push", cmd_push, 8'h01);
      acc(1'b1, CIF_MASK_ADDR, 8'h00);
      repeat (2) @(negedge clk);
      chk("irq", card_irq, 8'h01);
      acc(1'b1, CIF_DIV_ADDR, 8'h05);
      rst = 1'b1;
      repeat (2) @(negedge clk);
      rst = 1'b0;
      chk("rdata", sfr_rdata, CIF_PORT_RESET);
      chk("irq", card_irq, 8'h00);
      rd(CIF_MASK_ADDR, CIF_MASK_RESET, "mask");
      rd(CIF_DIV_ADDR, CIF_DIV_RESET, "div");
      rd(CIF_FLAGS_ADDR, CIF_FLAGS_RESET, "flags");
      $display("test second reset done");
      summarize();
   end
endmodule
